// file: verilog/i2c_pkg.sv
// Shared constants, register maps and state codes for both link ends
package i2c_pkg;
	// Slave register byte offsets on the Wishbone port
	localparam logic [7:0] OWN_OFS   = 8'h00;
	localparam logic [7:0] DATA_OFS  = 8'h04;
	localparam logic [7:0] CTRL_OFS  = 8'h08;
	localparam logic [7:0] STAT_OFS  = 8'h0c;
	// Control field positions
	localparam int EN_BIT   = 7;
	localparam int TX_BIT   = 4;
	localparam int ACKTX_BIT = 3;
	// Status field positions
	localparam int DONE_BIT  = 7;
	localparam int MATCH_BIT = 6;
	localparam int BUSY_BIT  = 5;
	localparam int RDREQ_BIT = 2;
	localparam int ACKRX_BIT = 0;
	// Reset values
	localparam logic [7:0] OWN_RST  = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	// Interrupt call target
	localparam logic [7:0] INT_VECTOR = 8'h14;
	// Master controller register byte offsets
	localparam logic [7:0] MCMD_OFS  = 8'h00;
	localparam logic [7:0] MTXD_OFS  = 8'h04;
	localparam logic [7:0] MSTAT_OFS = 8'h08;
	// Master command bits
	localparam int CMD_START = 0;
	localparam int CMD_WRITE = 1;
	localparam int CMD_READ  = 2;
	localparam int CMD_STOP  = 3;
	localparam int CMD_ACK   = 4;
	// Master status bits (received byte in 7:0)
	localparam int MST_BUSY = 8;
	localparam int MST_NACK = 9;
	// Link timing: a quarter of the generated clock period
	localparam int CLK_MHZ = 25;
	localparam int QTR_NS  = 640;
	localparam logic [4:0] QTR_CYC = 5'((QTR_NS * CLK_MHZ + 999) / 1000);
	// Slave sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_ADDR_ACK = 3'b010, S_HOLD = 3'b011,
		S_RX = 3'b100, S_RX_ACK = 3'b101, S_TX = 3'b110, S_TX_ACK = 3'b111
	} slave_state_e;
	// Master sequencer states
	typedef enum logic [1:0] {
		M_IDLE = 2'b00, M_START = 2'b01, M_BIT = 2'b10, M_STOP = 2'b11
	} master_state_e;
	// Register hit decode, shared by both ends
	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
		return adr == ofs;
	endfunction : reg_hit
endpackage : i2c_pkg

// file: verilog/i2c_link_if.sv
// Two-wire link carrier: open-drain wired-AND of both ends
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
	logic m_scl_o, m_scl_oe, m_sda_o, m_sda_oe; // Master drive
	logic s_scl_o, s_scl_oe, s_sda_o, s_sda_oe; // Slave drive
	logic scl, sda;                             // Resolved line levels
	// Pull-up wins unless someone drives low
	assign scl = !((m_scl_oe && !m_scl_o) || (s_scl_oe && !s_scl_o));
	assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
	modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
	modport slave  (output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe, input scl, sda);
endinterface : i2c_link_if
`default_nettype wire

// file: verilog/pin_sync3.sv
// Three-flop pin synchroniser; a change counts once flops two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
	parameter int W = 2
) (
	input  wire logic         clk_i, // System clock
	input  wire logic         rst_i, // Synchronous reset
	input  wire logic [W-1:0] d_i,   // Asynchronous pins
	output logic      [W-1:0] q_o    // Filtered levels
);
	logic [W-1:0] f1, f2, f3; // Synchroniser chain

	// Chain; first flop feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f1 <= '1;
			f2 <= '1;
			f3 <= '1;
		end else begin
			f1 <= d_i;
			f2 <= f1;
			f3 <= f2;
		end
	end

	// Accept a level only when stable over two samples
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_o <= '1;
		end else begin
			q_o <= (f2 == f3) ? f3 : q_o;
		end
	end
endmodule : pin_sync3
`default_nettype wire

// file: verilog/i2c_slave_end.sv
// Slave end of the two-wire link with a Wishbone register port
// Notes on behaviour
// - Own address in bits 7:1; bit 0 absent
// - Matching address selects this device
// - Enable bit 7 gates all transfers
// - Control bit 4 chooses transmit or receive
// - Bit 3 driven as ninth-clock acknowledge
// - Complete flag low during byte, high after
// - Match sets flag and interrupt request
// - Enabled, stack free: call vector 14H
// - Match flag cleared by data write, mismatch
// - Busy set on START, cleared on STOP
// - Eighth address bit stored as read flag
// - Ninth-clock acknowledge captured after sending
// - Sender releases data line on not-acknowledge
// - Seven address bits, MSB first, compared
// - One interrupt for match and byte
// - Drive low acknowledge after matched address
// - Hold clock low until data access
// - START is data fall with clock high
// - Eight-bit bytes, MSB first
// - Receiver acknowledges each byte with zero
// - Master stops after unanswered address
// - All data bytes pass the data register; the address byte stays in the shift register only
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_end
	import i2c_pkg::*;
(
	input  wire logic        clk_i,                  // System clock
	input  wire logic        rst_i,                  // Synchronous reset
	input  wire logic [7:0]  wb_adr_i,               // Byte address
	input  wire logic [31:0] wb_dat_i,               // Write data
	output logic      [31:0] wb_dat_o,               // Read data
	input  wire logic        wb_we_i,                // Write strobe
	input  wire logic [3:0]  wb_sel_i,               // Byte enables
	input  wire logic        wb_cyc_i,               // Cycle
	input  wire logic        wb_stb_i,               // Strobe
	output logic             wb_ack_o,               // Acknowledge
	input  wire logic        bus_interrupt_enable_i, // Interrupt enable
	input  wire logic        stack_full_i,           // Call stack full
	output logic             int_req_o,              // Request pulse
	output logic             int_call_o,             // Call pulse
	output logic      [7:0]  int_vector_o,           // Call target
	i2c_link_if.slave        link                    // Two-wire link
);
	import i2c_pkg::*;

	logic [6:0]   own_slave_address;   // Own address
	logic [7:0]   bus_data_buffer;     // Data register
	logic         bus_function_enable; // Enable
	logic         transmit_direction_select; // Direction
	logic         ack_to_send;         // Ack level to send
	logic         byte_transfer_complete;    // Byte done
	logic         address_match_flag;  // Selected
	logic         bus_busy_flag;       // Busy
	logic         master_read_request; // Read requested
	logic         ack_received_flag;   // Ack seen
	slave_state_e st;                  // Sequencer state
	logic [7:0]   shift;               // Shift register
	logic [2:0]   bitn;                // Bit count
	logic         ack_on;              // Driving ack low
	logic         hold;                // Holding clock low
	logic         event_p;             // Interrupt event
	logic [1:0]   lines, prev;         // Filtered scl, sda
	logic         scl_rise, scl_fall, start_c, stop_c;
	logic         req, wr, rd_data, wr_data;

	// Filter the link pins onto the system clock
	pin_sync3 #(.W(2)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({link.scl, link.sda}),
		.q_o   (lines)
	);

	// Edge history of filtered lines
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev <= 2'h3;
		end else begin
			prev <= lines;
		end
	end

	assign scl_rise = lines[1] && !prev[1];
	assign scl_fall = !lines[1] && prev[1];
	assign start_c  = lines[1] && prev[1] && prev[0] && !lines[0];
	assign stop_c   = lines[1] && prev[1] && !prev[0] && lines[0];

	// Bus request decode; effect taken on the request edge
	assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr      = req && wb_we_i && wb_sel_i[0];
	assign wr_data = wr && reg_hit(wb_adr_i, DATA_OFS);
	assign rd_data = req && !wb_we_i && reg_hit(wb_adr_i, DATA_OFS);

	// Acknowledge one cycle after the request, dropped the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// Read mux; unmapped offsets read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (req && !wb_we_i) begin
			if (reg_hit(wb_adr_i, OWN_OFS)) begin
				wb_dat_o <= {24'h0, own_slave_address, 1'b0};
			end else if (reg_hit(wb_adr_i, DATA_OFS)) begin
				wb_dat_o <= {24'h0, bus_data_buffer};
			end else if (reg_hit(wb_adr_i, CTRL_OFS)) begin
				wb_dat_o <= {24'h0, bus_function_enable, 2'b00,
					transmit_direction_select, ack_to_send, 3'b000};
			end else if (reg_hit(wb_adr_i, STAT_OFS)) begin
				wb_dat_o <= {24'h0, byte_transfer_complete, address_match_flag,
					bus_busy_flag, 2'b00, master_read_request, 1'b0, ack_received_flag};
			end else begin
				wb_dat_o <= 32'h0;
			end
		end
	end

	// Software-written configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			own_slave_address         <= OWN_RST[7:1];
			bus_function_enable       <= CTRL_RST[EN_BIT];
			transmit_direction_select <= CTRL_RST[TX_BIT];
			ack_to_send               <= CTRL_RST[ACKTX_BIT];
		end else if (wr && reg_hit(wb_adr_i, OWN_OFS)) begin
			own_slave_address <= wb_dat_i[7:1];
		end else if (wr && reg_hit(wb_adr_i, CTRL_OFS)) begin
			bus_function_enable       <= wb_dat_i[EN_BIT];
			transmit_direction_select <= wb_dat_i[TX_BIT];
			ack_to_send               <= wb_dat_i[ACKTX_BIT];
		end
	end

	// Bus busy tracks START and STOP whatever the enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_busy_flag <= 1'b0;
		end else if (start_c) begin
			bus_busy_flag <= 1'b1;
		end else if (stop_c) begin
			bus_busy_flag <= 1'b0;
		end
	end

	// Transfer sequencer, flags and data register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st                     <= S_IDLE;
			shift                  <= 8'h00;
			bitn                   <= 3'h0;
			ack_on                 <= 1'b0;
			hold                   <= 1'b0;
			event_p                <= 1'b0;
			bus_data_buffer        <= DATA_RST;
			byte_transfer_complete <= 1'b0;
			address_match_flag     <= 1'b0;
			master_read_request    <= 1'b0;
			ack_received_flag      <= 1'b0;
		end else begin
			event_p <= 1'b0;
			if (wr_data) begin
				bus_data_buffer    <= wb_dat_i[7:0];
				address_match_flag <= 1'b0;
			end
			if (!bus_function_enable) begin
				// Disabled: no transfer, lines released
				st     <= S_IDLE;
				ack_on <= 1'b0;
				hold   <= 1'b0;
			end else if (start_c) begin
				// Any START, repeated too, restarts addressing
				st     <= S_ADDR;
				bitn   <= 3'h0;
				ack_on <= 1'b0;
				hold   <= 1'b0;
			end else if (stop_c) begin
				st     <= S_IDLE;
				ack_on <= 1'b0;
				hold   <= 1'b0;
			end else begin
				unique case (st)
					S_IDLE: begin
						// Not addressed: wait for the next START
					end
					S_ADDR: if (scl_rise) begin
						shift <= {shift[6:0], lines[0]};
						bitn  <= bitn + 3'h1;
						if (bitn == 3'h7) begin
							if (shift[6:0] == own_slave_address) begin
								address_match_flag  <= 1'b1;
								master_read_request <= lines[0];
								event_p             <= 1'b1;
								byte_transfer_complete <= 1'b0;
								st <= S_ADDR_ACK;
							end else begin
								address_match_flag <= 1'b0;
								st <= S_IDLE;
							end
						end
					end
					S_ADDR_ACK, S_RX_ACK: if (scl_fall) begin
						if (!ack_on) begin
							// Ninth bit: address ack is always low
							ack_on <= (st == S_ADDR_ACK) || !ack_to_send;
						end else begin
							ack_on <= 1'b0;
							hold   <= 1'b1;
							st     <= S_HOLD;
						end
						if (ack_on && st == S_RX_ACK && ack_to_send) begin
							hold <= 1'b0;
							st   <= S_IDLE;
						end
					end
					S_HOLD: if (wr_data || rd_data) begin
						// Data access releases the clock and starts a byte
						hold <= 1'b0;
						bitn <= 3'h0;
						byte_transfer_complete <= 1'b0;
						shift <= wr_data ? wb_dat_i[7:0] : bus_data_buffer;
						st <= transmit_direction_select ? S_TX : S_RX;
					end
					S_RX: if (scl_rise) begin
						shift <= {shift[6:0], lines[0]};
						bitn  <= bitn + 3'h1;
						if (bitn == 3'h7) begin
							bus_data_buffer <= {shift[6:0], lines[0]};
							byte_transfer_complete <= 1'b1;
							event_p <= 1'b1;
							st <= S_RX_ACK;
						end
					end
					S_TX: if (scl_fall) begin
						shift <= {shift[6:0], 1'b1};
						bitn  <= bitn + 3'h1;
						if (bitn == 3'h7) begin
							st <= S_TX_ACK;
						end
					end
					S_TX_ACK: begin
						if (scl_rise) begin
							ack_received_flag      <= lines[0];
							byte_transfer_complete <= 1'b1;
							event_p                <= 1'b1;
						end else if (scl_fall) begin
							// Not-acknowledge: stay off the line until the next START
							hold <= !ack_received_flag;
							st   <= ack_received_flag ? S_IDLE : S_HOLD;
						end
					end
				endcase
			end
		end
	end

	// Shared interrupt request and gated call
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_req_o  <= 1'b0;
			int_call_o <= 1'b0;
		end else begin
			int_req_o  <= event_p;
			int_call_o <= event_p && bus_interrupt_enable_i && !stack_full_i;
		end
	end

	assign int_vector_o = INT_VECTOR;

	// Open-drain drive: outputs only ever pull low
	assign link.s_scl_o  = 1'b0;
	assign link.s_sda_o  = 1'b0;
	assign link.s_scl_oe = hold;
	assign link.s_sda_oe = ack_on || (st == S_TX && !shift[7]);
endmodule : i2c_slave_end
`default_nettype wire

// file: verilog/i2c_master_end.sv
// Master end of the two-wire link, commanded over Wishbone
`timescale 1ns/1ps
`default_nettype none
module i2c_master_end
	import i2c_pkg::*;
(
	input  wire logic        clk_i,    // System clock
	input  wire logic        rst_i,    // Synchronous reset
	input  wire logic [7:0]  wb_adr_i, // Byte address
	input  wire logic [31:0] wb_dat_i, // Write data
	output logic      [31:0] wb_dat_o, // Read data
	input  wire logic        wb_we_i,  // Write strobe
	input  wire logic [3:0]  wb_sel_i, // Byte enables
	input  wire logic        wb_cyc_i, // Cycle
	input  wire logic        wb_stb_i, // Strobe
	output logic             wb_ack_o, // Acknowledge
	i2c_link_if.master       link      // Two-wire link
);
	import i2c_pkg::*;

	master_state_e st;        // Sequencer state
	logic [1:0]    ph;        // Quarter phase
	logic [4:0]    cnt;       // Quarter timer
	logic          tick;      // Quarter elapsed
	logic          scl_low;   // Pulling clock low
	logic          sda_low;   // Pulling data low
	logic [8:0]    obits;     // Bits to send, ninth is ack
	logic [8:0]    ibits;     // Bits sampled
	logic [3:0]    nbit;      // Bit index
	logic          rd;        // Byte is a read
	logic          nack;      // Last write not acknowledged
	logic [7:0]    txd;       // Byte to send
	logic [7:0]    rxd;       // Byte received
	logic [1:0]    lines;     // Filtered scl, sda
	logic          req, go;

	// Filter the link pins
	pin_sync3 #(.W(2)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({link.scl, link.sda}),
		.q_o   (lines)
	);

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Commands while busy are ignored
	assign go  = req && wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, MCMD_OFS)
		&& st == M_IDLE;

	// Wishbone answer, read mux and transmit byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			txd      <= 8'h00;
		end else begin
			wb_ack_o <= req;
			if (req && wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, MTXD_OFS)) begin
				txd <= wb_dat_i[7:0];
			end
			if (req && !wb_we_i) begin
				if (reg_hit(wb_adr_i, MTXD_OFS)) begin
					wb_dat_o <= {24'h0, txd};
				end else if (reg_hit(wb_adr_i, MSTAT_OFS)) begin
					wb_dat_o <= {22'h0, nack, st != M_IDLE, rxd};
				end else begin
					wb_dat_o <= 32'h0;
				end
			end
		end
	end

	// Quarter timer; held at zero while a released clock is held low
	assign tick = (cnt == QTR_CYC - 5'h1);
	always_ff @(posedge clk_i) begin
		if (rst_i || st == M_IDLE || tick || (!scl_low && !lines[1])) begin
			cnt <= 5'h0;
		end else begin
			cnt <= cnt + 5'h1;
		end
	end

	// Command sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st      <= M_IDLE;
			ph      <= 2'h0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			obits   <= 9'h1ff;
			ibits   <= 9'h000;
			nbit    <= 4'h0;
			rd      <= 1'b0;
			nack    <= 1'b0;
			rxd     <= 8'h00;
		end else begin
			unique case (st)
				M_IDLE: begin
					ph   <= 2'h0;
					nbit <= 4'h0;
					if (go) begin
						if (wb_dat_i[CMD_START]) begin
							st <= M_START;
						end else if (wb_dat_i[CMD_WRITE]) begin
							obits <= {txd, 1'b1};
							rd    <= 1'b0;
							st    <= M_BIT;
						end else if (wb_dat_i[CMD_READ]) begin
							obits <= {8'hff, wb_dat_i[CMD_ACK]};
							rd    <= 1'b1;
							st    <= M_BIT;
						end else if (wb_dat_i[CMD_STOP]) begin
							st <= M_STOP;
						end
					end
				end
				M_START: if (tick) begin
					// Release data, release clock, data low, clock low
					ph <= ph + 2'h1;
					unique case (ph)
						2'h0: sda_low <= 1'b0;
						2'h1: scl_low <= 1'b0;
						2'h2: sda_low <= 1'b1;
						2'h3: begin
							scl_low <= 1'b1;
							st      <= M_IDLE;
						end
					endcase
				end
				M_BIT: if (tick) begin
					ph <= ph + 2'h1;
					unique case (ph)
						2'h0: sda_low <= !obits[8];
						2'h1: scl_low <= 1'b0;
						2'h2: ibits <= {ibits[7:0], lines[0]};
						2'h3: begin
							scl_low <= 1'b1;
							obits   <= {obits[7:0], 1'b1};
							nbit    <= nbit + 4'h1;
							if (nbit == 4'h8) begin
								sda_low <= 1'b0;
								rxd     <= ibits[8:1];
								nack    <= !rd && ibits[0];
								// Unanswered write ends with STOP
								st <= (!rd && ibits[0]) ? M_STOP : M_IDLE;
							end
						end
					endcase
				end
				M_STOP: if (tick) begin
					// Data low, release clock, release data, settle
					ph <= ph + 2'h1;
					unique case (ph)
						2'h0: sda_low <= 1'b1;
						2'h1: scl_low <= 1'b0;
						2'h2: sda_low <= 1'b0;
						2'h3: st <= M_IDLE;
					endcase
				end
			endcase
		end
	end

	assign link.m_scl_o  = 1'b0;
	assign link.m_sda_o  = 1'b0;
	assign link.m_scl_oe = scl_low;
	assign link.m_sda_oe = sda_low;
endmodule : i2c_master_end
`default_nettype wire

// file: verif/i2c_link_checker.sv
// Wire-level checks on the two-wire link between the two ends
`timescale 1ns/1ps
`default_nettype none
module i2c_link_checker (
	input wire logic clk_i,    // System clock
	input wire logic rst_i,    // Synchronous reset
	input wire logic m_scl_oe, // Master pulls clock
	input wire logic m_sda_oe, // Master pulls data
	input wire logic s_scl_oe, // Slave pulls clock
	input wire logic s_sda_oe, // Slave pulls data
	input wire logic scl,      // Resolved clock line
	input wire logic sda       // Resolved data line
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic       scl_q, sda_q; // Line levels one cycle back
	logic [3:0] bit_cnt;      // Clock rises since START, wraps after the ninth
	// Delay the lines so edges can be found
	always_ff @(posedge clk_i) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// Bit counter; a START restarts the frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_cnt <= 4'd0;
		end else if (scl && scl_q && sda_q && !sda) begin
			bit_cnt <= 4'd0;
		end else if (scl && !scl_q) begin
			bit_cnt <= (bit_cnt == 4'd9) ? 4'd1 : bit_cnt + 4'd1;
		end
	end
	sequence s_master_start;
		$rose(m_sda_oe) && scl;
	endsequence
	sequence s_bus_idle;
		(scl && sda) [*8];
	endsequence
	property p_start_shape;
		s_master_start |-> scl [*8];
	endproperty
	property p_stop_idle;
		$fell(m_sda_oe) && scl |=> s_bus_idle;
	endproperty
	property p_slave_sda_scl_low;
		$changed(s_sda_oe) |-> !scl && !$past(scl);
	endproperty
	property p_hold_from_low;
		$rose(s_scl_oe) |-> !$past(scl);
	endproperty
	property p_hold_on_ninth;
		$rose(s_scl_oe) |-> bit_cnt == 4'd9;
	endproperty
	property p_hold_length;
		$rose(s_scl_oe) |-> s_scl_oe [*8];
	endproperty
	property p_slave_window;
		scl && s_sda_oe |-> bit_cnt != 4'd0;
	endproperty
	property p_no_contention;
		scl && s_sda_oe |-> !m_sda_oe;
	endproperty
	a_start_shape: assert property (p_start_shape)
		else $error("START not held with clock high");
	a_stop_idle: assert property (p_stop_idle)
		else $error("lines not idle after STOP");
	a_slave_sda_scl_low: assert property (p_slave_sda_scl_low)
		else $error("slave moved data while clock high");
	a_hold_from_low: assert property (p_hold_from_low)
		else $error("slave hold began with clock high");
	a_hold_on_ninth: assert property (p_hold_on_ninth)
		else $error("slave hold not after ninth bit");
	a_hold_length: assert property (p_hold_length)
		else $error("slave hold released too early");
	a_slave_window: assert property (p_slave_window)
		else $error("slave drove data outside a frame");
	a_no_contention: assert property (p_no_contention)
		else $error("both ends drove data together");
endmodule : i2c_link_checker
`default_nettype wire

// file: verif/test_i2c_slave_interface.sv
// Bench joining the slave end and the master end over the link
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_interface;
	import i2c_pkg::*;
	logic        clk_i = 0;          // System clock
	logic        rst_i = 1;          // Reset, held at start
	logic [7:0]  adr = 0;            // Shared register address
	logic [31:0] wdat = 0;           // Shared write data
	logic        wen = 0;            // Write flag
	logic        s_cyc = 0;          // Slave cycle and strobe
	logic        m_cyc = 0;          // Master cycle and strobe
	logic        irq_en = 0;         // Interrupt enable
	logic        stk_full = 0;       // Call stack full
	logic [31:0] s_dout, m_dout;     // Read data
	logic        s_ack, m_ack;       // Bus answers
	logic        int_req, int_call;  // Interrupt pulses
	logic [7:0]  int_vec;            // Call target
	logic [31:0] q;                  // Last read value
	logic [6:0]  addr;               // Own address under test
	logic [7:0]  d;                  // Byte under test
	int          n_mismatch = 0, samples_checked = 0;
	int          n_req = 0, n_call = 0, exp_call = 0, r0;
	integer      seed = 32'h5eda;
	always #20 clk_i = ~clk_i;
	i2c_link_if link ();
	i2c_slave_end u_i2c_slave_end (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_dat_o(s_dout), .wb_we_i(wen), .wb_sel_i(4'h1),
		.wb_cyc_i(s_cyc), .wb_stb_i(s_cyc), .wb_ack_o(s_ack),
		.bus_interrupt_enable_i(irq_en), .stack_full_i(stk_full), .int_req_o(int_req),
		.int_call_o(int_call), .int_vector_o(int_vec), .link(link));
	i2c_master_end u_i2c_master_end (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_dat_o(m_dout), .wb_we_i(wen), .wb_sel_i(4'h1),
		.wb_cyc_i(m_cyc), .wb_stb_i(m_cyc), .wb_ack_o(m_ack), .link(link));
	i2c_link_checker u_i2c_link_checker (.clk_i(clk_i), .rst_i(rst_i),
		.m_scl_oe(link.m_scl_oe), .m_sda_oe(link.m_sda_oe), .s_scl_oe(link.s_scl_oe),
		.s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));
	// Count interrupt pulses; a call is expected only when enabled and stack free
	always @(posedge clk_i) begin
		if (!rst_i) begin
			n_req += int'(int_req);
			n_call += int'(int_call);
			exp_call += int'(int_req && irq_en && !stk_full);
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One classic cycle on either end; waits for the answer, no fixed latency
	task automatic bus(input logic sl, input logic [7:0] a, input logic we, input logic [7:0] v);
		@(posedge clk_i);
		adr <= a;
		wdat <= {24'h0, v};
		wen <= we;
		s_cyc <= sl;
		m_cyc <= !sl;
		do @(posedge clk_i); while ((sl ? s_ack : m_ack) !== 1'b1);
		q = sl ? s_dout : m_dout;
		s_cyc <= 1'b0;
		m_cyc <= 1'b0;
	endtask : bus
	// Master command, then poll until the master is idle again
	task automatic mop(input logic [7:0] cmd);
		bus(1'b0, MCMD_OFS, 1'b1, cmd);
		do bus(1'b0, MSTAT_OFS, 1'b0, 8'h00); while (q[MST_BUSY] !== 1'b0);
		// Let the slave's clock hold settle before software touches it
		repeat (8) @(posedge clk_i);
	endtask : mop
	// START plus address byte; interrupt gating drawn anew per frame
	task automatic frame(input logic [6:0] a, input logic rw);
		{irq_en, stk_full} <= 2'($random(seed));
		mop(8'(1 << CMD_START));
		bus(1'b0, MTXD_OFS, 1'b1, {a, rw});
		mop(8'(1 << CMD_WRITE));
	endtask : frame
	// Status expected right after an address match
	function automatic logic [31:0] exp_stat(input logic busy, input logic rd);
		logic [31:0] s;
		s = 32'h0;
		s[MATCH_BIT] = 1'b1;
		s[BUSY_BIT] = busy;
		s[RDREQ_BIT] = rd;
		return s;
	endfunction : exp_stat
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	// Hang guard, well beyond the expected run
	initial begin
		#(40 * 80000);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values and an unmapped offset all read zero
		bus(1'b1, OWN_OFS, 1'b0, 8'h00);
		chk(q, 0);
		bus(1'b1, STAT_OFS, 1'b0, 8'h00);
		chk(q, 0);
		bus(1'b1, 8'h10, 1'b0, 8'h00);
		chk(q, 0);
		addr = 7'($random(seed));
		bus(1'b1, OWN_OFS, 1'b1, {addr, 1'b1});
		bus(1'b1, OWN_OFS, 1'b0, 8'h00);
		chk(q, {24'h0, addr, 1'b0});
		// Disabled slave must not answer its own address
		frame(addr, 1'b0);
		chk(q[MST_NACK], 1);
		bus(1'b1, CTRL_OFS, 1'b1, 8'h80);
		// Neighbouring address is left unanswered
		frame(addr ^ 7'h01, 1'b0);
		chk(q[MST_NACK], 1);
		bus(1'b1, STAT_OFS, 1'b0, 8'h00);
		chk({q[MATCH_BIT], q[BUSY_BIT]}, 0);
		// Receive: match, then bytes with corner values, last one refused
		r0 = n_req;
		frame(addr, 1'b0);
		chk(q[MST_NACK], 0);
		bus(1'b1, STAT_OFS, 1'b0, 8'h00);
		chk(q, exp_stat(1'b1, 1'b0));
		chk(n_req - r0, 1);
		bus(1'b1, DATA_OFS, 1'b0, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			if (i == 3) bus(1'b1, CTRL_OFS, 1'b1, 8'h88);
			bus(1'b0, MTXD_OFS, 1'b1, d);
			mop(8'(1 << CMD_WRITE));
			chk(q[MST_NACK], i == 3);
			bus(1'b1, STAT_OFS, 1'b0, 8'h00);
			chk({q[DONE_BIT], q[BUSY_BIT]}, {1'b1, i != 3});
			bus(1'b1, DATA_OFS, 1'b0, 8'h00);
			chk(q, {24'h0, d});
		end
		// Transmit: acknowledged byte, then a refused one
		bus(1'b1, CTRL_OFS, 1'b1, 8'h90);
		frame(addr, 1'b1);
		chk(q[MST_NACK], 0);
		bus(1'b1, STAT_OFS, 1'b0, 8'h00);
		chk(q, exp_stat(1'b1, 1'b1));
		for (int i = 0; i < 2; i++) begin
			d = 8'($random(seed));
			bus(1'b1, DATA_OFS, 1'b1, d);
			if (i == 0) bus(1'b1, STAT_OFS, 1'b0, 8'h00);
			if (i == 0) chk(q[7:6], 0);
			mop(8'((1 << CMD_READ) | (i << CMD_ACK)));
			chk(q[7:0], d);
			bus(1'b1, STAT_OFS, 1'b0, 8'h00);
			chk(q[ACKRX_BIT], i);
		end
		mop(8'(1 << CMD_STOP));
		bus(1'b1, STAT_OFS, 1'b0, 8'h00);
		chk(q[BUSY_BIT], 0);
		chk(n_call, exp_call);
		chk(int_vec, 8'h14);
		wrap_up();
	end
endmodule : test_i2c_slave_interface
`default_nettype wire
